// ===== rtl/spq_exec_unit.sv
// Execution unit for stack pushes, program-space writes and upper-half multiply-accumulate
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// - Status/multiplicand push writes status then upper multiplicand half, SP plus two.
// - Auxiliary pointer push stores 32 bits at SP, SP plus two, one memory write.
// - Pointer zero to five pushes decode only when object code mode is one.
// - Pointer six and seven pushes decode in either object code mode.
// - Pushes ignore repeat, clear the repeat counter and leave flags alone.
// - Multiplicand push stores 32 bits at SP, SP plus two.
// - Program write copies the operand to program word at pointer seven.
// - Repeated program write runs N+1 times through a shadow address plus one.
// - Pointer seven reaches the full 22-bit program range.
// - Program accesses through pointer seven may reach data inside program range.
// - Operand field change to pointer seven wins over the post-increment.
// - Multiply-accumulate decodes only in mode one, two forms, repeatable.
// - Add shifted product to accumulator, then keep upper product half.
// - Post-increment form advances pointer seven by two per fetch.
// - Accumulator as repeated data operand is not trapped.
// - Zero flag from accumulator, negative flag from accumulator bit 31.
// - Carry flag follows the carry of the accumulate addition.
// - Overflow flag set on overflow, otherwise unchanged.
// - Without saturation the overflow counter steps up or down on overflow.
// - With saturation an overflowing accumulator clamps to the extreme values.
// - Product shift: positive logical left, negative arithmetic right.
// - Repeated accumulate runs N+1 times; overflow flag sticky across iterations.
module spq_exec_unit
  import spq_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic mem_valid,
  output logic mem_write,
  output logic mem_prog,
  output logic mem_wide,
  output logic [21:0] mem_addr,
  output logic [31:0] mem_wdata,
  input wire logic mem_ready,
  input wire logic [31:0] mem_rdata,
  output logic busy
);
  // ==========================================================================
  // Decoding
  function automatic spq_op_type decode(input logic [31:0] w, input logic obj);
    logic xar_hi;
    xar_hi = w[15:8] inside {OPC_AP0, OPC_AP1, OPC_AP2, OPC_AP3, OPC_AP4, OPC_AP5};
    decode = OP_NONE;
    if (w[31:16] == 16'h0000) begin
      if (w[15:0] == OPC_PUSH_TST0) decode = OP_PUSH_TST0;
      else if (w[15:0] == OPC_PUSH_MULT) decode = OP_PUSH_MULT;
      else if (w[7:0] == OPC_XAR_LO && xar_hi && obj) decode = OP_PUSH_XAR;
      else if (w[7:0] == OPC_XAR_LO && w[15:8] inside {OPC_AP6, OPC_AP7})
        decode = OP_PUSH_XAR;
      else if (w[15:8] == OPC_PWRITE) decode = OP_PWRITE;
    end else if (w[31:16] == OPC_QMAC_W1 && obj) begin
      if (w[15:8] == OPC_QMAC) decode = OP_QMAC;
      else if (w[15:8] == OPC_QMAC_INC) decode = OP_QMAC_INC;
    end
  endfunction

  function automatic logic [2:0] xar_index(input logic [7:0] hi);
    unique case (hi)
      OPC_AP0: xar_index = 3'd0;
      OPC_AP1: xar_index = 3'd1;
      OPC_AP2: xar_index = 3'd2;
      OPC_AP3: xar_index = 3'd3;
      OPC_AP4: xar_index = 3'd4;
      OPC_AP5: xar_index = 3'd5;
      OPC_AP6: xar_index = 3'd6;
      default: xar_index = 3'd7;
    endcase
  endfunction

  // ==========================================================================
  // Bus slave
  logic wr_q, rd_sel;
  logic [7:0] addr_q;
  logic [31:0] rd_d, hrdata_q;
  logic [31:0] ctrl_q, acc_q, p_q, mult_q, operand_q, loc7_q, instr_q;
  logic [15:0] sp_q, status_q, rep_cnt_q;
  logic rep_pend_q, unk_q;
  logic [31:0] xar_q [8];
  spq_state_type state_q;
  spq_op_type op_q;

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_q;
  assign rd_sel = hsel && htrans[1] && hready && !hwrite;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q <= 1'b0;
      addr_q <= 8'h00;
      hrdata_q <= 32'h0000_0000;
    end else begin
      wr_q <= hsel && htrans[1] && hready && hwrite;
      if (hsel && htrans[1] && hready) addr_q <= haddr[7:0];
      if (rd_sel) hrdata_q <= rd_d;
    end
  end

  always_comb begin
    rd_d = 32'h0000_0000;
    unique case (haddr[7:0])
      OFS_INSTR: rd_d = instr_q;
      OFS_CTRL: rd_d = ctrl_q;
      OFS_REPEAT: rd_d = {15'h0000, rep_pend_q, rep_cnt_q};
      OFS_SP: rd_d = {16'h0000, sp_q};
      OFS_STATUS0: rd_d = {16'h0000, status_q};
      OFS_MULT: rd_d = mult_q;
      OFS_ACC: rd_d = acc_q;
      OFS_PROD: rd_d = p_q;
      OFS_OPERAND: rd_d = operand_q;
      OFS_LOC7: rd_d = loc7_q;
      OFS_BUSY: rd_d = {30'h0000_0000, unk_q, busy};
      default: if (haddr[7:0] >= OFS_XAR_BASE && haddr[7:0] <= OFS_XAR_LAST) rd_d = xar_q[haddr[4:2]];
    endcase
  end

  logic sw_wr, start;
  spq_op_type dec_op;
  assign busy = state_q != ST_IDLE;
  assign sw_wr = wr_q && !busy;
  assign dec_op = decode(hwdata, ctrl_q[CTRL_OBJ]);
  assign start = sw_wr && addr_q == OFS_INSTR;

  // ==========================================================================
  // Control registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q <= CTRL_RST;
      mult_q <= 32'h0000_0000;
      operand_q <= 32'h0000_0000;
      loc7_q <= 32'h0000_0000;
      instr_q <= 32'h0000_0000;
      unk_q <= 1'b0;
    end else if (sw_wr) begin
      if (addr_q == OFS_CTRL) ctrl_q <= hwdata;
      if (addr_q == OFS_MULT) mult_q <= hwdata;
      if (addr_q == OFS_OPERAND) operand_q <= hwdata;
      if (addr_q == OFS_LOC7) loc7_q <= hwdata;
      if (start) begin
        instr_q <= hwdata;
        unk_q <= dec_op == OP_NONE;
      end
    end
  end

  // ==========================================================================
  // Sequencer
  logic [15:0] iter_q;
  logic [21:0] shadow_q;
  logic [2:0] dly_q, xidx_q;
  logic step, last, is_push, is_mac;
  assign step = state_q == ST_WAIT && mem_ready;
  assign last = iter_q == 16'h0000;
  assign is_push = op_q inside {OP_PUSH_TST0, OP_PUSH_XAR, OP_PUSH_MULT};
  assign is_mac = op_q inside {OP_QMAC, OP_QMAC_INC};

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= ST_IDLE;
      op_q <= OP_NONE;
      iter_q <= 16'h0000;
      shadow_q <= 22'h000000;
      dly_q <= 3'd0;
      xidx_q <= 3'd0;
    end else begin
      unique case (state_q)
        ST_IDLE: if (start && dec_op != OP_NONE) begin
          op_q <= dec_op;
          xidx_q <= xar_index(hwdata[15:8]);
          iter_q <= rep_pend_q ? rep_cnt_q : 16'h0000;
          shadow_q <= xar_q[7][21:0];
          dly_q <= dec_op == OP_PWRITE ? PWRITE_LAT - 3'd1 : 3'd0;
          state_q <= dec_op inside {OP_PWRITE, OP_QMAC, OP_QMAC_INC} ? ST_DELAY : ST_ISSUE;
        end
        ST_DELAY: begin
          dly_q <= dly_q - 3'd1;
          if (dly_q == 3'd0) state_q <= ST_ISSUE;
        end
        ST_ISSUE: state_q <= ST_WAIT;
        ST_WAIT: if (mem_ready) begin
          if (op_q == OP_PWRITE) shadow_q <= shadow_q + PWR_STEP;
          if (op_q == OP_QMAC_INC) shadow_q <= shadow_q + QMAC_STEP;
          if (is_push || last) state_q <= ST_IDLE;
          else begin
            iter_q <= iter_q - 16'h0001;
            state_q <= ST_ISSUE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rep_cnt_q <= 16'h0000;
      rep_pend_q <= 1'b0;
    end else if (start) begin
      rep_cnt_q <= 16'h0000;
      rep_pend_q <= 1'b0;
    end else if (sw_wr && addr_q == OFS_REPEAT) begin
      rep_cnt_q <= hwdata[15:0];
      rep_pend_q <= 1'b1;
    end
  end

  // ==========================================================================
  // Memory port
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mem_valid <= 1'b0;
      mem_write <= 1'b0;
      mem_prog <= 1'b0;
      mem_wide <= 1'b0;
      mem_addr <= 22'h000000;
      mem_wdata <= 32'h0000_0000;
    end else if (state_q == ST_ISSUE) begin
      mem_valid <= 1'b1;
      mem_write <= !is_mac;
      mem_prog <= !is_push;
      mem_wide <= op_q != OP_PWRITE;
      mem_addr <= is_push ? {6'h00, sp_q} : shadow_q;
      unique case (op_q)
        OP_PUSH_TST0: mem_wdata <= {mult_q[31:16], status_q};
        OP_PUSH_XAR: mem_wdata <= xar_q[xidx_q];
        OP_PUSH_MULT: mem_wdata <= mult_q;
        OP_PWRITE: mem_wdata <= {16'h0000, operand_q[15:0]};
        default: mem_wdata <= 32'h0000_0000;
      endcase
    end else if (mem_ready) begin
      mem_valid <= 1'b0;
    end
  end

  // ==========================================================================
  // Stack pointer and auxiliary pointers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) sp_q <= SP_RST;
    else if (step && is_push) sp_q <= sp_q + SP_STEP;
    else if (sw_wr && addr_q == OFS_SP) sp_q <= hwdata[15:0];
  end

  logic ptr_done;
  assign ptr_done = step && last && (op_q == OP_PWRITE || is_mac);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < 8; i++) xar_q[i] <= 32'h0000_0000;
    end else if (ptr_done && ctrl_q[CTRL_LOC7]) begin
      xar_q[7] <= loc7_q;
    end else if (ptr_done && op_q == OP_QMAC_INC) begin
      xar_q[7] <= {10'h000, shadow_q + QMAC_STEP};
    end else if (sw_wr && addr_q >= OFS_XAR_BASE && addr_q <= OFS_XAR_LAST) begin
      xar_q[addr_q[4:2]] <= hwdata;
    end
  end

  // ==========================================================================
  // Multiply-accumulate datapath
  logic signed [PSM_W-1:0] psm;
  logic [PSM_W-1:0] psm_mag;
  logic [31:0] sh, res, acc_new;
  logic signed [31:0] sh_right;
  logic [32:0] sum;
  logic [63:0] prod;
  logic ovf, pos_ovf;
  always_comb begin
    psm = ctrl_q[CTRL_PSM_LSB +: PSM_W];
    psm_mag = psm[PSM_W-1] ? PSM_W'(~psm + 1'b1) : psm;
    sh_right = $signed(p_q) >>> psm_mag;
    sh = psm[PSM_W-1] ? sh_right : p_q << psm_mag;
    sum = {1'b0, acc_q} + {1'b0, sh};
    res = sum[31:0];
    ovf = acc_q[31] == sh[31] && res[31] != acc_q[31];
    pos_ovf = ovf && !acc_q[31];
    acc_new = ovf && ctrl_q[CTRL_SAT] ? (pos_ovf ? ACC_MAX_POS : ACC_MAX_NEG) : res;
    prod = $signed({{32{operand_q[31]}}, operand_q})
      * $signed({{32{mem_rdata[31]}}, mem_rdata});
  end

  logic mac_step;
  assign mac_step = step && is_mac;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      acc_q <= 32'h0000_0000;
      p_q <= 32'h0000_0000;
      status_q <= 16'h0000;
    end else if (mac_step) begin
      acc_q <= acc_new;
      p_q <= prod[63:32];
      status_q[ST_Z] <= acc_new == 32'h0000_0000;
      status_q[ST_N] <= acc_new[31];
      status_q[ST_C] <= sum[32];
      if (ovf) status_q[ST_V] <= 1'b1;
      if (ovf && !ctrl_q[CTRL_SAT]) begin
        status_q[ST_OFLCNT_LSB +: OFLCNT_W] <= pos_ovf ?
          status_q[ST_OFLCNT_LSB +: OFLCNT_W] + 6'h01 :
          status_q[ST_OFLCNT_LSB +: OFLCNT_W] - 6'h01;
      end
    end else if (sw_wr) begin
      if (addr_q == OFS_ACC) acc_q <= hwdata;
      if (addr_q == OFS_PROD) p_q <= hwdata;
      if (addr_q == OFS_STATUS0) status_q <= hwdata[15:0];
    end
  end

  // ==========================================================================
  // Checks
  sequence pwr_start_s;
    state_q == ST_IDLE && start && dec_op == OP_PWRITE;
  endsequence
  sequence pwr_delay_s;
    ##1 (state_q == ST_DELAY) [*4] ##1 (state_q == ST_ISSUE);
  endsequence
  pwrite_delay_a: assert property (@(posedge hclk) disable iff (!hresetn)
    pwr_start_s |-> pwr_delay_s) else $error("program write delay wrong");
  push_sp_a: assert property (@(posedge hclk) disable iff (!hresetn)
    step && is_push |=> sp_q == $past(sp_q) + SP_STEP) else $error("push sp step wrong");
  push_rpt_a: assert property (@(posedge hclk) disable iff (!hresetn)
    start |=> rep_cnt_q == 16'h0000 && !rep_pend_q) else $error("repeat not cleared");
  tst0_data_a: assert property (@(posedge hclk) disable iff (!hresetn)
    state_q == ST_ISSUE && op_q == OP_PUSH_TST0 |=> mem_wdata == {mult_q[31:16], status_q}
    && mem_addr == {6'h00, sp_q}) else $error("status push data wrong");
  xar_obj_a: assert property (@(posedge hclk) disable iff (!hresetn)
    state_q == ST_IDLE && start && !ctrl_q[CTRL_OBJ] && hwdata == {16'h0000, OPC_AP0, OPC_XAR_LO}
    |=> state_q == ST_IDLE) else $error("pointer push decoded in mode zero");
  shadow_inc_a: assert property (@(posedge hclk) disable iff (!hresetn)
    step && op_q == OP_PWRITE |=> shadow_q == $past(shadow_q) + PWR_STEP)
    else $error("shadow address not advanced");
  zero_neg_a: assert property (@(posedge hclk) disable iff (!hresetn)
    mac_step |=> status_q[ST_Z] == (acc_q == 32'h0000_0000) && status_q[ST_N] == acc_q[31])
    else $error("zero or negative flag wrong");
  v_sticky_a: assert property (@(posedge hclk) disable iff (!hresetn)
    mac_step && (status_q[ST_V] || ovf) |=> status_q[ST_V]) else $error("overflow flag lost");
  sat_clamp_a: assert property (@(posedge hclk) disable iff (!hresetn)
    mac_step && ovf && ctrl_q[CTRL_SAT] |=> acc_q == ACC_MAX_POS || acc_q == ACC_MAX_NEG)
    else $error("saturation clamp wrong");
  push_flags_a: assert property (@(posedge hclk) disable iff (!hresetn)
    step && is_push |=> $stable(status_q)) else $error("push changed flags");
endmodule // spq_exec_unit
`default_nettype wire

// ===== rtl/spq_pkg.sv
// Shared constants and types for the push, program-write and multiply-accumulate unit
`default_nettype none
package spq_pkg;
  // ==========================================================================
  // Register offsets
  localparam logic [7:0] OFS_INSTR = 8'h00;
  localparam logic [7:0] OFS_CTRL = 8'h04;
  localparam logic [7:0] OFS_REPEAT = 8'h08;
  localparam logic [7:0] OFS_SP = 8'h0c;
  localparam logic [7:0] OFS_STATUS0 = 8'h10;
  localparam logic [7:0] OFS_MULT = 8'h14;
  localparam logic [7:0] OFS_ACC = 8'h18;
  localparam logic [7:0] OFS_PROD = 8'h1c;
  localparam logic [7:0] OFS_OPERAND = 8'h20;
  localparam logic [7:0] OFS_LOC7 = 8'h24;
  localparam logic [7:0] OFS_BUSY = 8'h28;
  localparam logic [7:0] OFS_XAR_BASE = 8'h40;
  localparam logic [7:0] OFS_XAR_LAST = 8'h5c;
  // ==========================================================================
  // Field positions and reset values
  localparam int CTRL_OBJ = 0;
  localparam int CTRL_SAT = 1;
  localparam int CTRL_LOC7 = 2;
  localparam int CTRL_PSM_LSB = 4;
  localparam int PSM_W = 4;
  localparam int ST_C = 0;
  localparam int ST_Z = 1;
  localparam int ST_N = 2;
  localparam int ST_V = 3;
  localparam int ST_OFLCNT_LSB = 10;
  localparam int OFLCNT_W = 6;
  localparam int BUSY_UNK = 1;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [15:0] SP_RST = 16'h0400;
  localparam int PROG_AW = 22;
  localparam logic [31:0] ACC_MAX_POS = 32'h7fff_ffff;
  localparam logic [31:0] ACC_MAX_NEG = 32'h8000_0000;
  // ==========================================================================
  // Encodings
  localparam logic [15:0] OPC_PUSH_TST0 = 16'h7619;
  localparam logic [15:0] OPC_PUSH_MULT = 16'habbd;
  localparam logic [7:0] OPC_XAR_LO = 8'hbd;
  localparam logic [7:0] OPC_AP0 = 8'h3a;
  localparam logic [7:0] OPC_AP1 = 8'hb2;
  localparam logic [7:0] OPC_AP2 = 8'haa;
  localparam logic [7:0] OPC_AP3 = 8'ha2;
  localparam logic [7:0] OPC_AP4 = 8'ha8;
  localparam logic [7:0] OPC_AP5 = 8'ha0;
  localparam logic [7:0] OPC_AP6 = 8'hc2;
  localparam logic [7:0] OPC_AP7 = 8'hc3;
  localparam logic [7:0] OPC_PWRITE = 8'h26;
  localparam logic [15:0] OPC_QMAC_W1 = 16'h564f;
  localparam logic [7:0] OPC_QMAC = 8'hc7;
  localparam logic [7:0] OPC_QMAC_INC = 8'h87;
  // ==========================================================================
  // Timing and steps
  localparam logic [2:0] PWRITE_LAT = 3'd4;
  localparam logic [15:0] SP_STEP = 16'h0002;
  localparam logic [21:0] PWR_STEP = 22'h000001;
  localparam logic [21:0] QMAC_STEP = 22'h000002;
  typedef enum logic [2:0] {
    OP_NONE, OP_PUSH_TST0, OP_PUSH_XAR, OP_PUSH_MULT, OP_PWRITE, OP_QMAC, OP_QMAC_INC
  } spq_op_type;
  typedef enum logic [1:0] {ST_IDLE, ST_DELAY, ST_ISSUE, ST_WAIT} spq_state_type;
endpackage
`default_nettype wire

// ===== test/spq_mem_model.sv
// Unified program and data memory answering the unit's requests
`timescale 1ns/10ps
`default_nettype none
module spq_mem_model (
  input wire logic hclk,
  input wire logic slow,
  input wire logic mem_valid,
  input wire logic mem_write,
  input wire logic mem_prog,
  input wire logic mem_wide,
  input wire logic [21:0] mem_addr,
  input wire logic [31:0] mem_wdata,
  output logic mem_ready,
  output logic [31:0] mem_rdata
);
  logic [31:0] mem [0:255];
  logic [31:0] last;
  initial begin
    mem_ready = 1'b1;
    last = 32'h0;
  end
  // ==========
  // One array serves both spaces
  always @(posedge hclk) begin
    if (mem_valid && mem_ready && mem_write)
      mem[mem_addr[7:0]] <= mem_wide ? mem_wdata : {16'h0, mem_wdata[15:0]};
    mem_ready <= !slow || ($urandom % 3 == 0);
    last <= mem_rdata;
  end
  // Read data only while answering, noise otherwise
  always @* begin
    if (mem_valid && mem_ready && !mem_write)
      mem_rdata = mem[mem_addr[7:0]];
    else
      mem_rdata = ~last;
  end
endmodule // spq_mem_model
`default_nettype wire

// ===== test/stack_push_pwrite_qmac_exec_tb.sv
// Self-checking bench for the push, program-write and multiply-accumulate unit
`timescale 1ns/10ps
`default_nettype none
module stack_push_pwrite_qmac_exec_tb;
  import spq_pkg::*;
  logic hclk, hresetn, hsel, hwrite, slow, rd_ph, mem_ready;
  logic [31:0] haddr, hwdata, hrdata, mem_wdata, mem_rdata, v, st, m, sp;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic hreadyout, hresp, mem_valid, mem_write, mem_prog, mem_wide, busy;
  logic [21:0] mem_addr;
  logic [63:0] e;
  logic [55:0] me;
  logic [63:0] rdq [$];
  logic [55:0] memq [$];
  logic [7:0] xop [8] = '{OPC_AP0, OPC_AP1, OPC_AP2, OPC_AP3,
                          OPC_AP4, OPC_AP5, OPC_AP6, OPC_AP7};
  int n_errors = 0;
  int n_compared = 0;
  wire logic hready = hreadyout;
  spq_exec_unit i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .mem_valid(mem_valid),
    .mem_write(mem_write), .mem_prog(mem_prog), .mem_wide(mem_wide), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_ready(mem_ready), .mem_rdata(mem_rdata), .busy(busy));
  spq_mem_model i_mem (.hclk(hclk), .slow(slow), .mem_valid(mem_valid),
    .mem_write(mem_write), .mem_prog(mem_prog), .mem_wide(mem_wide), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_ready(mem_ready), .mem_rdata(mem_rdata));
  initial begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end
  // ==========
  // Bus tasks
  task automatic end_of_test();
    if (n_errors == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic cmp(input string nm, input logic [63:0] ex, input logic [63:0] got);
    n_compared++;
    if (got !== ex) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, ex, got);
    end
  endtask
  task automatic cmp_mem(input logic [55:0] ex, input logic [55:0] got);
    n_compared++;
    if (got !== ex) begin
      n_errors++;
      $display("MISMATCH memory write expected %h seen %h", ex, got);
    end
  endtask
  task automatic wait_rdy();
    int k;
    k = 0;
    do begin
      @(posedge hclk);
      k++;
    end while (hready !== 1'b1 && k < 50);
    if (hready !== 1'b1) begin
      n_errors++;
      end_of_test();
    end
  endtask
  task automatic ahb(input logic [7:0] a, input logic w, input logic [31:0] d);
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'b10;
    hsel <= 1'b1;
    wait_rdy();
    htrans <= 2'b00;
    hwdata <= d;
    rd_ph <= ~w;
    wait_rdy();
    rd_ph <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    ahb(a, 1'b1, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] ex,
                    input logic [31:0] mk = 32'hffffffff);
    rdq.push_back({mk, ex});
    ahb(a, 1'b0, 32'h0);
  endtask
  task automatic run(input logic [31:0] ins);
    int k;
    k = 0;
    wr(OFS_INSTR, ins);
    repeat (2) @(posedge hclk);
    while (busy !== 1'b0 && k < 2000) begin
      @(posedge hclk);
      k++;
    end
    if (busy !== 1'b0) begin
      n_errors++;
      end_of_test();
    end
  endtask
  task automatic qcase(input logic signed [3:0] psm, input logic sat, input logic [31:0] acc,
    input logic [31:0] p, input logic [31:0] op, input logic [31:0] w0, input int n,
    input logic inc, input logic [31:0] st0);
    logic [31:0] a, pr, sh, w;
    logic [32:0] sum;
    logic signed [63:0] pd;
    logic [5:0] oflcnt;
    logic vf, c, ov;
    int s;
    wr(OFS_CTRL, {24'h0, psm, 2'b00, sat, 1'b1});
    wr(OFS_ACC, acc);
    wr(OFS_PROD, p);
    wr(OFS_OPERAND, op);
    wr(OFS_STATUS0, st0);
    wr(OFS_XAR_BASE + 8'h1c, 32'h10);
    wr(OFS_REPEAT, 32'(n));
    a = acc;
    pr = p;
    vf = st0[ST_V];
    oflcnt = st0[15:10];
    s = psm;
    for (int i = 0; i <= n; i++) begin
      w = inc ? w0 + 32'(i) : w0;
      i_mem.mem[8'h10 + 8'(2 * i)] = w;
      if (s < 0)
        sh = $signed(pr) >>> (-s);
      else
        sh = pr << s;
      sum = {1'b0, a} + {1'b0, sh};
      ov = (a[31] == sh[31]) && (sum[31] != a[31]);
      c = sum[32];
      a = sum[31:0];
      if (ov) vf = 1'b1;
      if (ov && sat) a = sh[31] ? ACC_MAX_NEG : ACC_MAX_POS;
      if (ov && !sat) oflcnt = sh[31] ? oflcnt - 6'd1 : oflcnt + 6'd1;
      pd = $signed(op) * $signed(w);
      pr = pd[63:32];
    end
    run({OPC_QMAC_W1, inc ? OPC_QMAC_INC : OPC_QMAC, 8'h00});
    rd(OFS_ACC, a);
    rd(OFS_PROD, pr);
    rd(OFS_STATUS0, {16'h0, oflcnt, 6'h0, vf, a[31], a == 32'h0, c}, 32'hfc0f);
    rd(OFS_XAR_BASE + 8'h1c, inc ? 32'h10 + 32'(2 * (n + 1)) : 32'h10);
  endtask
  // ==========
  // Result watcher
  always @(posedge hclk) begin
    if (rd_ph === 1'b1 && hready === 1'b1) begin
      e = rdq.pop_front();
      cmp("register", {32'h0, e[31:0]}, {32'h0, hrdata & e[63:32]});
      cmp("response", 64'h0, {63'h0, hresp});
    end
    if (mem_valid && mem_ready && mem_write) begin
      me = (memq.size() > 0) ? memq.pop_front() : 'x;
      cmp_mem(me, {mem_prog, mem_wide, mem_addr,
        mem_wide ? mem_wdata[31:16] : 16'h0, mem_wdata[15:0]});
    end
  end
  // ==========
  // Main sequence
  initial begin
    {hresetn, hsel, hwrite, slow, rd_ph, haddr, htrans, hwdata} = '0;
    hsize = 3'b010;
    void'($urandom(32'h70f1));
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(OFS_SP, {16'h0, SP_RST});
    rd(OFS_CTRL, CTRL_RST);
    rd(8'h30, 32'h0);
    sp = {16'h0, SP_RST};
    for (int o = 0; o < 2; o++) begin
      slow <= o[0];
      wr(OFS_CTRL, 32'(o));
      for (int n = 0; n < 8; n++) begin
        v = $urandom;
        st = $urandom & 32'hfc0f;
        wr(OFS_XAR_BASE + 8'(4 * n), v);
        wr(OFS_STATUS0, st);
        wr(OFS_REPEAT, $urandom % 5 + 1);
        if (o == 1 || n > 5) memq.push_back({2'b01, sp[21:0], v});
        if (o == 1 || n > 5) sp += 2;
        run({16'h0, xop[n], OPC_XAR_LO});
        rd(OFS_BUSY, (o == 1 || n > 5) ? 32'h0 : 32'h2);
        rd(OFS_SP, sp);
        rd(OFS_STATUS0, st);
        if (o == 1 || n > 5) rd(OFS_REPEAT, 32'h0);
      end
    end
    m = $urandom;
    wr(OFS_MULT, m);
    wr(OFS_REPEAT, 32'h3);
    memq.push_back({2'b01, sp[21:0], m[31:16], st[15:0]});
    run({16'h0, OPC_PUSH_TST0});
    memq.push_back({2'b01, sp[21:0] + 22'd2, m});
    run({16'h0, OPC_PUSH_MULT});
    sp += 4;
    rd(OFS_SP, sp);
    slow <= 1'b0;
    wr(OFS_XAR_BASE + 8'h1c, 32'h003ffffd);
    wr(OFS_OPERAND, v);
    wr(OFS_REPEAT, 32'h2);
    for (int i = 0; i < 3; i++)
      memq.push_back({2'b10, 22'h3ffffd + 22'(i), 16'h0, v[15:0]});
    run({16'h0, OPC_PWRITE, 8'h00});
    rd(OFS_XAR_BASE + 8'h1c, 32'h003ffffd);
    wr(OFS_CTRL, 32'h5);
    wr(OFS_LOC7, 32'h123);
    memq.push_back({2'b10, 22'h3ffffd, 16'h0, v[15:0]});
    run({16'h0, OPC_PWRITE, 8'h00});
    rd(OFS_XAR_BASE + 8'h1c, 32'h123);
    wr(OFS_CTRL, 32'h0);
    run({OPC_QMAC_W1, OPC_QMAC, 8'h00});
    rd(OFS_BUSY, 32'h2);
    qcase(-3, 0, $urandom & 32'h0fffffff, $urandom, $urandom, $urandom, 0, 0, 32'h8);
    qcase(0, 0, 32'h7fffffff, 32'h1, $urandom, $urandom, 0, 1, 32'h0);
    qcase(0, 1, 32'h80000000, 32'hffffffff, $urandom, $urandom, 0, 0, 32'h0);
    qcase(1, 1, 32'h7ffffff0, 32'h10, 32'h80000000, 32'h40000000, 2, 1, 32'h0);
    qcase(-8, 0, $urandom & 32'h3fffffff, $urandom, $urandom, $urandom, 1, 0, 32'h0);
    cmp("queued writes", 64'h0, 64'(memq.size()));
    end_of_test();
  end
endmodule // stack_push_pwrite_qmac_exec_tb
`default_nettype wire
